// File: hdl/audio_in_pkg.sv
// constants shared by the serial audio input port
package audio_in_pkg;
	localparam int NUM_CH     = 8;
	localparam int WORD_W     = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int FRAME_BITS = 64;
	// framing select per channel
	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_LJ  = 2'h1;
	localparam logic [1:0] FMT_RJ  = 2'h2;
	// sample width select per channel
	localparam logic [2:0] WID_16 = 3'h0;
	localparam logic [2:0] WID_18 = 3'h1;
	localparam logic [2:0] WID_20 = 3'h2;
	localparam logic [2:0] WID_24 = 3'h3;
	localparam logic [2:0] WID_32 = 3'h4;
	// bit position counter saturates here
	localparam logic [5:0] POS_MAX = 6'h3f;
endpackage

// File: hdl/serial_audio_input_port.sv
// serial audio input port: per-channel receivers, shared word fifo
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// word fifo with valid/ready on both sides
module audio_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       rstn_in,
	// fill side
	input  wire logic                       wr_valid_in,
	output logic                            wr_ready_out,
	input  wire logic [WIDTH-1:0]           wr_data_in,
	// drain side
	output logic                            rd_valid_out,
	input  wire logic                       rd_ready_in,
	output logic [WIDTH-1:0]                rd_data_out,
	// status
	output logic [$clog2(DEPTH+1)-1:0]      level_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0]          mem [DEPTH];
	logic [AW-1:0]             wr_ptr;
	logic [AW-1:0]             rd_ptr;
	logic [$clog2(DEPTH+1)-1:0] count;
	wire                       do_wr = wr_valid_in & wr_ready_out;
	wire                       do_rd = rd_valid_out & rd_ready_in;
	wire [AW-1:0]              next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
	wire [AW-1:0]              next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;

	assign wr_ready_out = (count != ($clog2(DEPTH+1))'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign rd_data_out  = mem[rd_ptr];
	assign level_out    = count;

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= next_wr_ptr;
			end
			if (do_rd) begin
				rd_ptr <= next_rd_ptr;
			end
			count <= count + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
		end
	end
endmodule // audio_word_fifo

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1: eight independent channels, own clock, sync, data
// RQ2: all channels merged into one 32x8 fifo
// RQ3: 64-bit frame split into two 32-bit words
// RQ4: each half-frame pushed as its own word
// RQ5: framing selectable: i2s, left- or right-justified
// RQ6: widths 24/32, right-justified also 20/18/16
// RQ7: word into full fifo dropped, sticky overflow
module serial_audio_input_port #(
	parameter int NUM_CH     = audio_in_pkg::NUM_CH,
	parameter int FIFO_DEPTH = audio_in_pkg::FIFO_DEPTH
) (
	// system clock and reset
	input  wire logic                                  sys_clk_in,
	input  wire logic                                  rstn_in,
	// serial channels
	input  wire logic [NUM_CH-1:0]                     ch_bclk_in,
	input  wire logic [NUM_CH-1:0]                     ch_fsync_in,
	input  wire logic [NUM_CH-1:0]                     ch_data_in,
	// channel configuration
	input  wire logic [NUM_CH-1:0]                     ch_enable_in,
	input  wire logic [2*NUM_CH-1:0]                   ch_format_in,
	input  wire logic [3*NUM_CH-1:0]                   ch_width_in,
	// fifo read side
	output logic                                       rd_valid_out,
	input  wire logic                                  rd_ready_in,
	output logic [audio_in_pkg::WORD_W-1:0]            rd_data_out,
	output logic [$clog2(FIFO_DEPTH+1)-1:0]            fifo_level_out,
	// overflow status
	output logic                                       overflow_out,
	input  wire logic                                  overflow_clr_in
);
	localparam int W = audio_in_pkg::WORD_W;

	// sample width in bits, i2s and left-justified limited to 24 or 32
	function automatic logic [5:0] wid_bits(input logic [2:0] code, input logic [1:0] fmt);
		logic [5:0] b;
		b = 6'h20;
		case (code)
			audio_in_pkg::WID_16: b = 6'h10;
			audio_in_pkg::WID_18: b = 6'h12;
			audio_in_pkg::WID_20: b = 6'h14;
			audio_in_pkg::WID_24: b = 6'h18;
			default:              b = 6'h20;
		endcase
		if (fmt != audio_in_pkg::FMT_RJ && b != 6'h18) begin
			b = 6'h20;
		end
		return b;
	endfunction

	logic [NUM_CH*W-1:0] link_word;
	logic [NUM_CH-1:0]   link_tog;
	logic [NUM_CH-1:0]   pend;
	logic [NUM_CH-1:0]   ovf_evt;
	logic [NUM_CH*W-1:0] pend_word;
	logic                push_ready;
	logic                overflow;

	wire [NUM_CH-1:0] pick   = pend & (~pend + 1'b1);
	wire              push_v = |pend;
	wire              accept = push_v & push_ready;
	wire [NUM_CH-1:0] gnt    = accept ? pick : '0;
	logic [W-1:0]     push_data;

	always_comb begin
		push_data = '0;
		for (int k = 0; k < NUM_CH; k++) begin
			push_data = push_data | (pick[k] ? pend_word[k*W +: W] : '0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-channel receiver and crossing
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic [5:0]   cfg_m;
		logic [5:0]   cfg;
		logic         fs_prev;
		logic         armed;
		logic         tog;
		logic [5:0]   cnt;
		logic [W-1:0] acc;
		logic [W-1:0] word;
		logic [2:0]   tsync;
		logic         pend_r;
		logic [W-1:0] pend_w;

		wire [1:0]   fmt      = cfg[4:3];
		wire         en       = cfg[5];
		wire [5:0]   wb       = wid_bits(cfg[2:0], fmt);
		wire         fs_edge  = ch_fsync_in[i] ^ fs_prev;
		wire [5:0]   pos      = fs_edge ? 6'h00 : cnt;
		wire         is_rj    = (fmt == audio_in_pkg::FMT_RJ);
		wire         is_i2s   = (fmt == audio_in_pkg::FMT_I2S);
		// RQ5: data alignment per framing
		wire         shift_en = is_rj | (is_i2s ? (pos != 6'h00 && pos <= wb) : (pos < wb));
		wire [W-1:0] base     = fs_edge ? '0 : acc;
		wire [W-1:0] next_acc = shift_en ? {base[W-2:0], ch_data_in[i]} : base;
		wire [5:0]   next_cnt = fs_edge ? 6'h01 : ((cnt == audio_in_pkg::POS_MAX) ? cnt : cnt + 6'h01);
		// RQ6: i2s lsb may fall on the boundary clock
		wire         lsb_late = is_i2s & (cnt == wb);
		wire [W-1:0] full_acc = lsb_late ? {acc[W-2:0], ch_data_in[i]} : acc;
		// RQ6: sample moved to msb-aligned word
		wire [W-1:0] aligned  = full_acc << (6'h20 - wb);
		wire         arrive   = tsync[2] ^ tsync[1];

		// RQ1: configuration brought into the channel's own clock
		always_ff @(posedge ch_bclk_in[i] or negedge rstn_in) begin
			if (!rstn_in) begin
				cfg_m <= 6'h00;
				cfg   <= 6'h00;
			end else begin
				cfg_m <= {ch_enable_in[i], ch_format_in[2*i +: 2], ch_width_in[3*i +: 3]};
				cfg   <= cfg_m;
			end
		end

		// RQ3: half-frame completes at each sync transition
		always_ff @(posedge ch_bclk_in[i] or negedge rstn_in) begin
			if (!rstn_in) begin
				fs_prev <= 1'b0;
				armed   <= 1'b0;
				tog     <= 1'b0;
				cnt     <= 6'h00;
				acc     <= '0;
				word    <= '0;
			end else begin
				fs_prev <= ch_fsync_in[i];
				cnt     <= next_cnt;
				acc     <= next_acc;
				if (fs_edge) begin
					armed <= en;
				end
				if (fs_edge && armed && en) begin
					word <= aligned;
					tog  <= ~tog;
				end
			end
		end

		assign link_word[i*W +: W] = word;
		assign link_tog[i]         = tog;

		// RQ4: one word per half-frame into the system clock
		always_ff @(posedge sys_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				tsync  <= 3'h0;
				pend_r <= 1'b0;
				pend_w <= '0;
			end else begin
				tsync <= {tsync[1:0], link_tog[i]};
				// RQ7: arrival into a full fifo is dropped
				if (arrive && push_ready) begin
					pend_r <= 1'b1;
					pend_w <= link_word[i*W +: W];
				end else if (gnt[i]) begin
					pend_r <= 1'b0;
				end
			end
		end

		assign pend[i]             = pend_r;
		assign pend_word[i*W +: W] = pend_w;

		// RQ7: lost word on full fifo or unsent slot
		assign ovf_evt[i] = arrive & (~push_ready | (pend[i] & ~gnt[i]));
	end

	////////////////////////////////////////////////////////////////////////////
	// shared fifo and overflow flag
	// RQ2: channels merged into one fifo
	audio_word_fifo #(
		.WIDTH (W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (sys_clk_in),
		.rstn_in      (rstn_in),
		.wr_valid_in  (push_v),
		.wr_ready_out (push_ready),
		.wr_data_in   (push_data),
		.rd_valid_out (rd_valid_out),
		.rd_ready_in  (rd_ready_in),
		.rd_data_out  (rd_data_out),
		.level_out    (fifo_level_out)
	);

	// RQ7: sticky flag, set wins over clear
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			overflow <= 1'b0;
		end else begin
			overflow <= (|ovf_evt) | (overflow & ~overflow_clr_in);
		end
	end

	assign overflow_out = overflow;
endmodule // serial_audio_input_port

`default_nettype wire

// File: testbench/serial_audio_input_port_assertions.sv
// read-side checker of the serial audio input port
`timescale 1ns/1ps
`default_nettype none
module audio_in_checker #(parameter int NUM_CH = 8, parameter int FIFO_DEPTH = 8) (
	// clock, reset, read side and status
	input wire logic                            sys_clk_in,
	input wire logic                            rstn_in,
	input wire logic                            rd_valid_out,
	input wire logic                            rd_ready_in,
	input wire logic [audio_in_pkg::WORD_W-1:0] rd_data_out,
	input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level_out,
	input wire logic                            overflow_out,
	input wire logic                            overflow_clr_in
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	level_bound_a: assert property (fifo_level_out <= FIFO_DEPTH)
		else $error("fifo level above depth");
	valid_level_a: assert property (rd_valid_out == (fifo_level_out != 0))
		else $error("valid does not follow level");
	head_hold_a: assert property (rd_valid_out && !rd_ready_in |=> $stable(rd_data_out))
		else $error("head word moved without pop");
	one_word_a: assert property (fifo_level_out - $past(fifo_level_out) inside {4'h0, 4'h1, 4'hf})
		else $error("level moved by more than one word");
	pop_level_a: assert property (rd_valid_out && rd_ready_in |=> fifo_level_out <= $past(fifo_level_out))
		else $error("level grew on pop");
	ovf_hold_a: assert property (overflow_out && !overflow_clr_in |=> overflow_out)
		else $error("overflow not sticky");
	ovf_cause_a: assert property ($rose(overflow_out) |-> $past(fifo_level_out) == FIFO_DEPTH)
		else $error("overflow without full fifo");
	ovf_clear_a: assert property (overflow_clr_in && !rd_valid_out |=> !overflow_out)
		else $error("overflow not cleared");
	cover property (fifo_level_out == FIFO_DEPTH);
	cover property ($rose(overflow_out));
	cover property (rd_valid_out && rd_ready_in);
endmodule // audio_in_checker
bind serial_audio_input_port audio_in_checker #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) chk_i (
	.sys_clk_in, .rstn_in, .rd_valid_out, .rd_ready_in, .rd_data_out, .fifo_level_out,
	.overflow_out, .overflow_clr_in);
`default_nettype wire

// File: testbench/audio_source.sv
// serial audio sources, one per channel
`timescale 1ns/1ps
`default_nettype none
module audio_source (
	// serial lines and framing of each channel
	output var logic  [7:0] bclk_out,
	output var logic  [7:0] fsync_out,
	output var logic  [7:0] data_out,
	input  wire logic [15:0] fmt_in,
	input  wire logic [23:0] wid_in
);
	logic [31:0] smp [8][4];
	initial {bclk_out, fsync_out, data_out} = 24'h000000;
	task automatic chan(input int k, input int n);
		logic [31:0] s;
		logic [31:0] p;
		logic [2:0] c;
		int m;
		int t;
		int wd;
		c = wid_in[3*k+:3];
		wd = c == 3'h3 ? 24 : c > 3'h3 ? 32 : 16 + 2 * c;
		s = 32'h0;
		#(k * 3);
		for (int h = -1; h <= n + 1; h++) begin
			p = s;
			s = smp[k][h > 0 && h <= n ? h : 0];
			m = h < 0 ? 10 + 4 * k : h > n ? 2 : 32;
			for (int b = 0; b < m; b++) begin
				t = b % 32;
				bclk_out[k] = 1'b0;
				fsync_out[k] = h >= 0 && h % 2 == 0;
				// alignment and width of the sample
				case (fmt_in[2*k+:2])
					audio_in_pkg::FMT_I2S: data_out[k] = t == 0 ? p[0] : s[(32 - t) % 32];
					audio_in_pkg::FMT_LJ: data_out[k] = s[31 - t];
					default: data_out[k] = t >= 32 - wd ? s[63 - wd - t] : s[t];
				endcase
				#15 bclk_out[k] = 1'b1;
				#15;
			end
		end
		bclk_out[k] = 1'b0;
		data_out[k] = ~data_out[k];
	endtask
	task automatic stream(input int n);
		for (int k = 0; k < 8; k++) fork
			automatic int q = k;
			chan(q, n);
		join_none
		wait fork;
	endtask
endmodule // audio_source
`default_nettype wire

// File: testbench/serial_audio_input_port_tb.sv
// self-checking bench of the serial audio input port
`timescale 1ns/1ps
`default_nettype none
module serial_audio_input_port_tb;
	logic             sys_clk_in = 1'b0;
	logic             rstn_in = 1'b0;
	logic             rd_ready_in = 1'b0;
	logic             overflow_clr_in = 1'b0;
	logic             rd_on = 1'b0;
	logic [7:0]       ch_enable_in = 8'hff;
	logic [15:0]      ch_format_in = 16'h0000;
	logic [23:0]      ch_width_in = 24'h000000;
	logic [15:0]      lf = 16'h0036;
	logic [31:0]      exp_q [$];
	int               err_total = 0;
	int               compares = 0;
	wire logic [7:0]  bclk, fsync, sdata;
	wire logic        rd_valid_out, overflow_out;
	wire logic [31:0] rd_data_out;
	wire logic [3:0]  fifo_level_out;
	always #10 sys_clk_in = ~sys_clk_in;
	audio_source src (.bclk_out(bclk), .fsync_out(fsync), .data_out(sdata),
		.fmt_in(ch_format_in), .wid_in(ch_width_in));
	serial_audio_input_port dut (.sys_clk_in, .rstn_in, .ch_bclk_in(bclk), .ch_fsync_in(fsync),
		.ch_data_in(sdata), .ch_enable_in, .ch_format_in, .ch_width_in, .rd_valid_out,
		.rd_ready_in, .rd_data_out, .fifo_level_out, .overflow_out, .overflow_clr_in);
	function automatic logic [15:0] step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic int wbits(input logic [1:0] f, input logic [2:0] c);
		return c == 3'h3 ? 24 : c > 3'h3 || f != audio_in_pkg::FMT_RJ ? 32 : 16 + 2 * c;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(negedge sys_clk_in) begin
		lf = step(lf);
		rd_ready_in = rd_on & lf[0];
		if (rd_ready_in && rd_valid_out === 1'b1)
			chk("word", exp_q.size() > 0 ? exp_q.pop_front() : 32'hx, rd_data_out);
	end
	task automatic scn(input logic [1:0] f, input logic [23:0] w, input logic [7:0] en,
		input logic rd);
		logic [31:0] s;
		@(negedge sys_clk_in);
		{rstn_in, rd_on, ch_format_in, ch_width_in, ch_enable_in} = {1'b0, rd, {8{f}}, w, en};
		exp_q.delete();
		for (int h = 0; h < 4; h++)
			for (int k = 0; k < 8; k++) begin
				s = {lf, step(lf)};
				lf = step(step(lf));
				src.smp[k][h] = s;
				// enabled channels only, dropped while full
				if (en[k] && (rd || exp_q.size() < 8))
					exp_q.push_back(s & ~(32'hffffffff >> wbits(f, w[3*k+:3])));
			end
		fork
			src.stream(3);
			begin
				repeat (5) @(negedge sys_clk_in);
				rstn_in = 1'b1;
			end
		join
		repeat (8) @(negedge sys_clk_in);
		if (!rd) begin
			chk("ovf", 1, overflow_out);
			chk("level", audio_in_pkg::FIFO_DEPTH, fifo_level_out);
		end
		rd_on = 1'b1;
		for (int i = 0; i < 400 && exp_q.size() > 0; i++)
			@(negedge sys_clk_in);
		chk("left", 0, exp_q.size());
		overflow_clr_in = 1'b1;
		@(negedge sys_clk_in);
		overflow_clr_in = 1'b0;
		@(negedge sys_clk_in);
		chk("ovf", 0, overflow_out);
	endtask
	initial begin
		repeat (3) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		scn(audio_in_pkg::FMT_LJ, {4{3'h4, 3'h3}}, 8'hff, 1'b1);
		scn(audio_in_pkg::FMT_I2S, {4{3'h4, 3'h3}}, 8'hff, 1'b1);
		scn(audio_in_pkg::FMT_RJ, {2{3'h3, 3'h2, 3'h1, 3'h0}}, 8'hf7, 1'b1);
		scn(audio_in_pkg::FMT_LJ, {8{3'h4}}, 8'hff, 1'b0);
		print_verdict();
	end
	initial begin
		#200us;
		err_total++;
		print_verdict();
	end
endmodule // serial_audio_input_port_tb
`default_nettype wire
